// >>> src/cfdc_cfg.svh
`ifndef CFDC_CFG_SVH
`define CFDC_CFG_SVH

// Register byte offsets.
`define CFDC_OFF_SCALE      12'h01c
`define CFDC_OFF_COEF_OFS   12'h020
`define CFDC_OFF_DECIM      12'h024
`define CFDC_OFF_NTAPS      12'h028
`define CFDC_OFF_MIN_PER    12'h02c
`define CFDC_OFF_LOW_TH     12'h030
`define CFDC_OFF_UP_TH      12'h034
`define CFDC_OFF_CTRL       12'h038
`define CFDC_OFF_PEAK_WORD  12'h03c
`define CFDC_OFF_ESTIMATE0  12'h040
`define CFDC_OFF_COEF_BASE  12'h100

// Reset values.
`define CFDC_RST_SCALE      2'h3
`define CFDC_RST_DECIM      3'h0
`define CFDC_RST_NTAPS      6'h00
`define CFDC_RST_MIN_PER    5'h04
`define CFDC_RST_LOW_TH     5'h14
`define CFDC_RST_UP_TH      5'h04

// Field positions.
`define CFDC_CTRL_DC_EN     0

// Accumulator headroom above the data width.
`define CFDC_HEADROOM       3

`endif

// >>> src/cfdc_pkg.sv
package cfdc_pkg;

    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } cfdc_sample_type;

    typedef struct packed {
        logic [4:0] min_period;
        logic [4:0] low_th;
        logic [4:0] up_th;
        logic       enable;
    } cfdc_dc_cfg_type;

    typedef enum logic [2:0] {
        CF_IDLE = 3'b001,
        CF_MAC  = 3'b010,
        CF_OUT  = 3'b100
    } cfdc_fstate_type;

endpackage

// >>> src/cfdc_dc_path.sv
`timescale 1ns/1ps
`include "cfdc_cfg.svh"

module cfdc_dc_path
    import cfdc_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            ce,
    input  wire cfdc_dc_cfg_type cfg,
    input  wire cfdc_sample_type in_s,
    output cfdc_sample_type      out_s,
    output logic [4:0]           peak_word,
    output logic [23:0]          estimate
);
    typedef struct packed {
        logic        started;
        logic [22:0] peak;
        logic [35:0] cnt;
        logic [4:0]  stage;
        logic [59:0] acc;
        logic [23:0] est;
        cfdc_sample_type out;
    } cfdc_dc_state_type;

    cfdc_dc_state_type s_q;
    cfdc_dc_state_type s_d;
    logic [22:0] mag;
    logic [22:0] pk;
    logic [4:0]  word;
    logic [5:0]  shift;
    logic [24:0] diff;

    // Power word in 6 dB steps below full scale: count of leading zeros.
    function automatic logic [4:0] cfdc_lz(input logic [22:0] v);
        logic [4:0] n;
        n = 5'h17;
        for (int i = 0; i < 23; i++) begin
            if (v[i]) begin
                n = 5'(22 - i);
            end
        end
        return n;
    endfunction

    always_comb begin
        s_d   = s_q;
        mag   = in_s.data[23] ? 23'(-in_s.data) : in_s.data[22:0];
        // The most negative sample has no 23-bit magnitude, so it reads as full scale.
        mag   = (in_s.data == 24'h800000) ? 23'h7fffff : mag;
        pk    = (mag > s_q.peak) ? mag : s_q.peak;
        word  = cfdc_lz(pk);
        // Lower level means more zeros; a larger step count lengthens the period.
        shift = 6'(cfg.min_period) + 6'(((cfg.low_th > word) ? (cfg.low_th - word) : 5'h0) << 1);
        diff  = {in_s.data[23], in_s.data} - {s_q.est[23], s_q.est};
        s_d.out.valid = in_s.valid;
        if (in_s.valid) begin
            if (!cfg.enable) begin
                s_d.out.data = in_s.data;
            end else if (diff[24] != diff[23]) begin
                s_d.out.data = diff[24] ? 24'h800000 : 24'h7fffff;
            end else begin
                s_d.out.data = diff[23:0];
            end
            if (!s_q.started) begin
                s_d.started = 1'b1;
                s_d.peak    = mag;
                s_d.cnt     = 36'(1) << cfg.min_period;
                s_d.stage   = 5'h0;
                s_d.acc     = 60'(signed'(in_s.data));
            end else if (word < cfg.up_th) begin
                // Track the newest magnitude so that the peak can fall once the burst ends.
                s_d.peak  = mag;
                s_d.cnt   = 36'(1) << cfg.min_period;
                s_d.stage = 5'h0;
                s_d.acc   = 60'(signed'(in_s.data));
            end else if (s_q.cnt <= 36'h1) begin
                s_d.est   = 24'(signed'(s_q.acc) >>> (cfg.min_period + 5'(s_q.stage << 1)));
                s_d.acc   = 60'(signed'(in_s.data));
                s_d.peak  = mag;
                s_d.cnt   = 36'(1) << cfg.min_period;
                s_d.stage = 5'h0;
            end else begin
                s_d.peak = pk;
                s_d.acc  = s_q.acc + 60'(signed'(in_s.data));
                s_d.cnt  = s_q.cnt - 36'h1;
                if (word < cfg.low_th && 5'(shift - 6'(cfg.min_period)) > 5'(s_q.stage << 1)) begin
                    s_d.stage = 5'((shift - 6'(cfg.min_period)) >> 1);
                    s_d.cnt   = (36'(1) << cfg.min_period) << (s_d.stage << 1);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign out_s     = s_q.out;
    assign peak_word = cfdc_lz(s_q.peak);
    assign estimate  = s_q.est;
endmodule

// >>> src/cfdc_fir.sv
`timescale 1ns/1ps
`include "cfdc_cfg.svh"

module cfdc_fir
    import cfdc_pkg::*;
#(
    parameter int TAPS = 48
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        in_valid,
    input  wire logic [22:0] in_i,
    input  wire logic [22:0] in_q,
    input  wire logic [2:0]  decim_m1,
    input  wire logic [5:0]  ntaps_m1,
    input  wire logic [5:0]  coef_ofs,
    input  wire logic [1:0]  scale,
    input  wire logic        cw_en,
    input  wire logic [5:0]  cw_addr,
    input  wire logic [19:0] cw_data,
    output logic             out_valid,
    output logic [23:0]      out_i,
    output logic [23:0]      out_q
);
    typedef struct packed {
        cfdc_fstate_type st;
        logic [2:0]  dcnt;
        logic [5:0]  tap;
        logic [46:0] acc_i;
        logic [46:0] acc_q;
        logic        ov;
        logic [23:0] oi;
        logic [23:0] oq;
    } cfdc_fir_state_type;

    cfdc_fir_state_type s_q;
    cfdc_fir_state_type s_d;
    logic [19:0] cmem [TAPS];
    logic [22:0] di [TAPS];
    logic [22:0] dq [TAPS];
    logic [5:0]  ca;
    logic [19:0] c;

    // Coefficients are Q3.17 here so that a gain of 8 fits; scale picks the window.
    function automatic logic [23:0] cfdc_pick(input logic [46:0] a, input logic [1:0] sc);
        logic [46:0] r;
        logic [5:0]  lsb;
        lsb = 6'(20 - 32'(sc));
        r   = a + (47'(1) << (lsb - 6'h1));
        return 24'(r >> lsb);
    endfunction

    always_ff @(posedge clk) begin
        if (ce && cw_en) begin
            cmem[cw_addr] <= cw_data;
        end
        if (ce && in_valid) begin
            for (int k = TAPS - 1; k > 0; k--) begin
                di[k] <= di[k-1];
                dq[k] <= dq[k-1];
            end
            di[0] <= in_i;
            dq[0] <= in_q;
        end
    end

    assign ca = 6'(coef_ofs + s_q.tap);
    assign c  = cmem[ca];

    always_comb begin
        s_d    = s_q;
        s_d.ov = 1'b0;
        // Inputs that arrive while a product sum runs still count toward decimation.
        if (in_valid) begin
            s_d.dcnt = (s_q.dcnt == decim_m1) ? 3'h0 : s_q.dcnt + 3'h1;
        end
        case (s_q.st)
            CF_IDLE: begin
                if (in_valid && s_q.dcnt == decim_m1) begin
                    s_d.st    = CF_MAC;
                    s_d.tap   = 6'h0;
                    s_d.acc_i = '0;
                    s_d.acc_q = '0;
                end
            end
            CF_MAC: begin
                // oldest sample meets the first coefficient.
                s_d.acc_i = s_q.acc_i + 47'(signed'(c) * signed'(di[ntaps_m1 - s_q.tap]));
                s_d.acc_q = s_q.acc_q + 47'(signed'(c) * signed'(dq[ntaps_m1 - s_q.tap]));
                s_d.tap   = s_q.tap + 6'h1;
                if (s_q.tap == ntaps_m1) begin
                    s_d.st = CF_OUT;
                end
            end
            CF_OUT: begin
                s_d.oi = cfdc_pick(s_q.acc_i, scale);
                s_d.oq = cfdc_pick(s_q.acc_q, scale);
                s_d.ov = 1'b1;
                s_d.st = CF_IDLE;
            end
            default: begin
                s_d.st = CF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q    <= '0;
            s_q.st <= CF_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign out_valid = s_q.ov;
    assign out_i     = s_q.oi;
    assign out_q     = s_q.oq;
endmodule

// >>> src/cfdc_top.sv
// What this block does
// - Filter begins at coefficient address given by coefficient offset.
// - Output rate equals IIR rate divided by decimation factor.
// - Two-bit output scale at 0x1C, 6 dB steps, 0 to -18 dB.
// - Recirculating MAC keeps three headroom bits, up to eight times input.
// - Four-way mux picks 24 accumulator bits with matching rounding.
// - Filter gain is coefficient sum over two to the three minus scale.
// - Dc correction sits after the filter and runs continuously.
// - Accumulate samples, form estimate, subtract it from every sample.
// - Subtraction saturates instead of wrapping.
// - Higher signal level lengthens integration, lower shortens it.
// - First sample loads peak and loads counter with minimum period.
// - Each sample magnitude replaces held peak when larger.
// - Below lower threshold counter decrements; at zero updates and restarts.
// - Above upper threshold estimate in progress discarded, old one kept.
// - Four independent dc paths: A and B, in-phase and quadrature.
// - Peak encoded as power word in 6 dB steps below full scale.
// - Between thresholds counter reloads with four times period per step.
// - At zero, estimate updated and accumulator loaded with current sample.
// - Above upper threshold counter held at minimum period.
`timescale 1ns/1ps
`include "cfdc_cfg.svh"

module cfdc_top
    import cfdc_pkg::*;
#(
    parameter int TAPS = 48
)(
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic        HSEL,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        IN_VALID_A,
    input  wire logic [22:0] IN_I_A,
    input  wire logic [22:0] IN_Q_A,
    input  wire logic        IN_VALID_B,
    input  wire logic [22:0] IN_I_B,
    input  wire logic [22:0] IN_Q_B,
    output cfdc_sample_type  OUT_AI,
    output cfdc_sample_type  OUT_AQ,
    output cfdc_sample_type  OUT_BI,
    output cfdc_sample_type  OUT_BQ
);
    // ==========================================================
    // Register state
    // ==========================================================
    typedef struct packed {
        logic [1:0]  scale;
        logic [5:0]  coef_ofs;
        logic [2:0]  decim;
        logic [5:0]  ntaps;
        cfdc_dc_cfg_type dc;
        logic        wr_pend;
        logic [11:0] addr;
        logic [31:0] rdata;
    } cfdc_reg_type;

    cfdc_reg_type r_q;
    cfdc_reg_type r_d;
    logic         cw_en;
    logic [5:0]   cw_addr;
    logic [4:0]   pw [4];
    logic [23:0]  est [4];
    cfdc_sample_type fo [4];
    cfdc_sample_type dco [4];
    logic         fa_v;
    logic         fb_v;
    logic [23:0]  fa_i, fa_q, fb_i, fb_q;
    logic         take;

    assign take = HSEL && HREADY && HTRANS[1];

    function automatic logic [31:0] cfdc_read(input cfdc_reg_type r, input logic [11:0] a,
                                               input logic [19:0] p, input logic [95:0] e);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            `CFDC_OFF_SCALE:     v = 32'(r.scale);
            `CFDC_OFF_COEF_OFS:  v = 32'(r.coef_ofs);
            `CFDC_OFF_DECIM:     v = 32'(r.decim);
            `CFDC_OFF_NTAPS:     v = 32'(r.ntaps);
            `CFDC_OFF_MIN_PER:   v = 32'(r.dc.min_period);
            `CFDC_OFF_LOW_TH:    v = 32'(r.dc.low_th);
            `CFDC_OFF_UP_TH:     v = 32'(r.dc.up_th);
            `CFDC_OFF_CTRL:      v = 32'(r.dc.enable);
            `CFDC_OFF_PEAK_WORD: v = 32'(p);
            `CFDC_OFF_ESTIMATE0:       v = 32'(e[23:0]);
            `CFDC_OFF_ESTIMATE0 + 12'h4: v = 32'(e[47:24]);
            `CFDC_OFF_ESTIMATE0 + 12'h8: v = 32'(e[71:48]);
            `CFDC_OFF_ESTIMATE0 + 12'hc: v = 32'(e[95:72]);
            default:             v = 32'h0;
        endcase
        return v;
    endfunction

    always_comb begin
        r_d         = r_q;
        cw_en       = 1'b0;
        cw_addr     = 6'(r_q.addr[7:2]);
        r_d.wr_pend = 1'b0;
        if (r_q.wr_pend) begin
            case (r_q.addr)
                `CFDC_OFF_SCALE:    r_d.scale         = HWDATA[1:0];
                `CFDC_OFF_COEF_OFS: r_d.coef_ofs      = HWDATA[5:0];
                `CFDC_OFF_DECIM:    r_d.decim         = HWDATA[2:0];
                `CFDC_OFF_NTAPS:    r_d.ntaps         = HWDATA[5:0];
                `CFDC_OFF_MIN_PER:  r_d.dc.min_period = HWDATA[4:0];
                `CFDC_OFF_LOW_TH:   r_d.dc.low_th     = HWDATA[4:0];
                `CFDC_OFF_UP_TH:    r_d.dc.up_th      = HWDATA[4:0];
                `CFDC_OFF_CTRL:     r_d.dc.enable     = HWDATA[`CFDC_CTRL_DC_EN];
                default: begin
                    cw_en = (r_q.addr[11:8] == 4'h1) && (r_q.addr[7:2] < 6'(TAPS));
                end
            endcase
        end
        if (take) begin
            r_d.addr    = HADDR;
            r_d.wr_pend = HWRITE;
            r_d.rdata   = cfdc_read(r_q, HADDR, {pw[3], pw[2], pw[1], pw[0]},
                                    {est[3], est[2], est[1], est[0]});
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            r_q               <= '0;
            r_q.scale         <= `CFDC_RST_SCALE;
            r_q.decim         <= `CFDC_RST_DECIM;
            r_q.ntaps         <= `CFDC_RST_NTAPS;
            r_q.dc.min_period <= `CFDC_RST_MIN_PER;
            r_q.dc.low_th     <= `CFDC_RST_LOW_TH;
            r_q.dc.up_th      <= `CFDC_RST_UP_TH;
            r_q.dc.enable     <= 1'b1;
        end else if (CE) begin
            r_q <= r_d;
        end
    end

    assign HRDATA    = r_q.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // ==========================================================
    // Filters and dc paths
    // ==========================================================
    cfdc_fir #(.TAPS(TAPS)) u_fir_a (
        .clk(CLOCK), .rst_n(RST_N), .ce(CE), .in_valid(IN_VALID_A),
        .in_i(IN_I_A), .in_q(IN_Q_A), .decim_m1(r_q.decim), .ntaps_m1(r_q.ntaps),
        .coef_ofs(r_q.coef_ofs), .scale(r_q.scale), .cw_en(cw_en), .cw_addr(cw_addr),
        .cw_data(HWDATA[19:0]), .out_valid(fa_v), .out_i(fa_i), .out_q(fa_q)
    );

    cfdc_fir #(.TAPS(TAPS)) u_fir_b (
        .clk(CLOCK), .rst_n(RST_N), .ce(CE), .in_valid(IN_VALID_B),
        .in_i(IN_I_B), .in_q(IN_Q_B), .decim_m1(r_q.decim), .ntaps_m1(r_q.ntaps),
        .coef_ofs(r_q.coef_ofs), .scale(r_q.scale), .cw_en(cw_en), .cw_addr(cw_addr),
        .cw_data(HWDATA[19:0]), .out_valid(fb_v), .out_i(fb_i), .out_q(fb_q)
    );

    assign fo[0] = '{valid: fa_v, data: fa_i};
    assign fo[1] = '{valid: fa_v, data: fa_q};
    assign fo[2] = '{valid: fb_v, data: fb_i};
    assign fo[3] = '{valid: fb_v, data: fb_q};

    for (genvar g = 0; g < 4; g++) begin : g_dc
        cfdc_dc_path u_dc (
            .clk(CLOCK), .rst_n(RST_N), .ce(CE), .cfg(r_q.dc), .in_s(fo[g]),
            .out_s(dco[g]), .peak_word(pw[g]), .estimate(est[g])
        );
    end

    assign OUT_AI = dco[0];
    assign OUT_AQ = dco[1];
    assign OUT_BI = dco[2];
    assign OUT_BQ = dco[3];
endmodule

// >>> tb/cfdc_top_properties.sv
`timescale 1ns/1ps

module cfdc_top_properties
    import cfdc_pkg::*;
#(
    parameter int TAPS = 48
)(
    input wire logic            CLOCK,
    input wire logic            RST_N,
    input wire logic            CE,
    input wire logic            HSEL,
    input wire logic [11:0]     HADDR,
    input wire logic [1:0]      HTRANS,
    input wire logic            HWRITE,
    input wire logic            HREADY,
    input wire logic [31:0]     HRDATA,
    input wire logic            HREADYOUT,
    input wire logic            HRESP,
    input wire logic            IN_VALID_A,
    input wire logic            IN_VALID_B,
    input wire cfdc_sample_type OUT_AI,
    input wire cfdc_sample_type OUT_AQ,
    input wire cfdc_sample_type OUT_BI,
    input wire cfdc_sample_type OUT_BQ
);
    logic [7:0] since_a_q;
    logic [7:0] since_b_q;
    logic       taken;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    assign taken = HSEL && HREADY && HTRANS[1] && CE;

    // =====
    // Cycles since the last input sample of each channel, saturating.
    always_ff @(posedge CLOCK) begin
        since_a_q <= (!RST_N || IN_VALID_A) ? 8'h00 : since_a_q + {7'h00, since_a_q != 8'hff};
        since_b_q <= (!RST_N || IN_VALID_B) ? 8'h00 : since_b_q + {7'h00, since_b_q != 8'hff};
    end

    // =====
    // Bus and stream checks.
    a_ready_high: assert property (HREADYOUT)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!HRESP)
        else $error("error response on the bus");
    a_read_holds: assert property (!taken |=> $stable(HRDATA))
        else $error("read data moved without a transfer");
    a_unmapped_zero: assert property (taken && !HWRITE && HADDR >= 12'h800 |=> HRDATA == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_pulse_single: assert property (OUT_AI.valid |=> !OUT_AI.valid)
        else $error("output valid longer than one cycle");
    a_iq_together: assert property (OUT_AI.valid == OUT_AQ.valid && OUT_BI.valid == OUT_BQ.valid)
        else $error("in-phase and quadrature outputs out of step");
    a_rate_chan_a: assert property (OUT_AI.valid |-> since_a_q <= TAPS + 4)
        else $error("channel A output without a recent input");
    a_rate_chan_b: assert property (OUT_BI.valid |-> since_b_q <= TAPS + 4)
        else $error("channel B output without a recent input");

    c_dc_removed: cover property (OUT_AI.valid && OUT_AI.data == 24'h000000);
    c_clamped: cover property (OUT_AI.valid && OUT_AI.data == 24'h7fffff);
    c_read_taken: cover property (taken && !HWRITE);
endmodule

// >>> tb/cfdc_src_model.sv
`timescale 1ns/1ps

module cfdc_src_model #(
    parameter int GAP = 12
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [22:0] set_i,
    input  wire logic [22:0] set_q,
    output logic             vld   = 1'b0,
    output logic [22:0]      smp_i = 23'h000000,
    output logic [22:0]      smp_q = 23'h000000
);
    int cnt = 0;

    // =====
    // One sample every GAP cycles; between samples the lines toggle so stale data is never valid.
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 0;
            vld <= 1'b0;
        end else begin
            cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
            vld <= (cnt == 0);
            smp_i <= (cnt == 0) ? set_i : ~smp_i;
            smp_q <= (cnt == 0) ? set_q : ~smp_q;
        end
    end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "cfdc_cfg.svh"

module testbench
    import cfdc_pkg::*;
;
    localparam int TAPS = 48;

    logic            clock  = 1'b0;
    logic            rst_n  = 1'b0;
    logic            hsel   = 1'b0;
    logic [11:0]     haddr  = 12'h000;
    logic [1:0]      htrans = 2'h0;
    logic            hwrite = 1'b0;
    logic [2:0]      hsize  = 3'h2;
    logic [31:0]     hwdata = 32'h0;
    wire logic       hready;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic [22:0]     set_ai = 23'h0;
    logic [22:0]     set_aq = 23'h0;
    logic [22:0]     set_bi = 23'h0;
    logic [22:0]     set_bq = 23'h0;
    logic            vld_a;
    logic            vld_b;
    logic [22:0]     smp_ai;
    logic [22:0]     smp_aq;
    logic [22:0]     smp_bi;
    logic [22:0]     smp_bq;
    cfdc_sample_type out_ai;
    cfdc_sample_type out_aq;
    cfdc_sample_type out_bi;
    cfdc_sample_type out_bq;
    logic [23:0]     last_ai;
    logic [23:0]     last_aq;
    logic [23:0]     last_bi;
    logic [23:0]     last_bq;
    int              n_in_a      = 0;
    int              n_out_a     = 0;
    int              miscompares = 0;
    int              n_compared  = 0;
    int              v;
    int              i0;

    always #12.5 clock = ~clock;
    assign hready = hreadyout;

    cfdc_top #(.TAPS(TAPS)) i_cfdc_top (
        .CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .IN_VALID_A(vld_a), .IN_I_A(smp_ai), .IN_Q_A(smp_aq),
        .IN_VALID_B(vld_b), .IN_I_B(smp_bi), .IN_Q_B(smp_bq),
        .OUT_AI(out_ai), .OUT_AQ(out_aq), .OUT_BI(out_bi), .OUT_BQ(out_bq));

    cfdc_src_model i_src_a (.clk(clock), .rst_n(rst_n), .set_i(set_ai), .set_q(set_aq),
        .vld(vld_a), .smp_i(smp_ai), .smp_q(smp_aq));
    cfdc_src_model i_src_b (.clk(clock), .rst_n(rst_n), .set_i(set_bi), .set_q(set_bq),
        .vld(vld_b), .smp_i(smp_bi), .smp_q(smp_bq));

    always @(posedge clock) begin
        if (vld_a === 1'b1) n_in_a++;
        if (out_ai.valid === 1'b1) begin
            n_out_a++;
            last_ai = out_ai.data;
            last_aq = out_aq.data;
        end
        if (out_bi.valid === 1'b1) begin
            last_bi = out_bi.data;
            last_bq = out_bq.data;
        end
    end

    // =====
    // Bus access, comparison and closing tasks.
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic cmp_reg(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_smp(input string what, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        cmp_reg(what, e & m, r & m);
    endtask

    task automatic wait_out(input int n);
        int t;
        t = n_out_a + n;
        repeat (4000) begin
            @(posedge clock);
            if (n_out_a >= t) break;
        end
        if (n_out_a < t) cmp_reg("output pulses", 32'(t), 32'(n_out_a));
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
    endtask

    // Two taps of 1.0 at address 0 and two of 3.0 at address 5; absolute sums stay below 8.
    // Dc settings go first, so that the paths start on them right after a reset.
    task automatic setup(input logic [31:0] ctrl);
        wr(`CFDC_OFF_MIN_PER, 32'h2);
        wr(`CFDC_OFF_LOW_TH, 32'hc);
        wr(`CFDC_OFF_UP_TH, 32'h4);
        wr(`CFDC_OFF_CTRL, ctrl);
        for (int k = 0; k < 7; k++) wr(`CFDC_OFF_COEF_BASE + 12'(4 * k),
            (k < 2) ? 32'h20000 : (k > 4) ? 32'h60000 : 32'h0);
        wr(`CFDC_OFF_NTAPS, 32'h1);
        wr(`CFDC_OFF_COEF_OFS, 32'h0);
        wr(`CFDC_OFF_DECIM, 32'h0);
        wr(`CFDC_OFF_SCALE, 32'h3);
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        give_verdict();
    end

    // =====
    // Test sequence.
    initial begin
        do_reset();
        rd_chk("scale after reset", `CFDC_OFF_SCALE, 32'h3, 32'(`CFDC_RST_SCALE));
        for (int s = 0; s < 4; s++) begin
            wr(`CFDC_OFF_SCALE, 32'(s));
            rd_chk("scale", `CFDC_OFF_SCALE, 32'h3, 32'(s));
        end
        rd_chk("unmapped word", 12'h800, 32'hffffffff, 32'h0);
        $display("register test done");

        set_ai <= 23'h100000;
        set_aq <= 23'h700000;
        set_bi <= 23'h080000;
        setup(32'h0);
        wait_out(4);
        cmp_smp("offset 0 A-I", 24'h200000, last_ai);
        cmp_smp("offset 0 A-Q", 24'he00000, last_aq);
        cmp_smp("offset 0 B-I", 24'h100000, last_bi);
        wr(`CFDC_OFF_COEF_OFS, 32'h5);
        for (int s = 0; s < 4; s++) begin
            wr(`CFDC_OFF_SCALE, 32'(s));
            wait_out(4);
            v = 'h600000;
            v = v >>> (3 - s);
            cmp_smp("scaled A-I", 24'(v), last_ai);
            cmp_smp("scaled A-Q", 24'(-v), last_aq);
        end
        wr(`CFDC_OFF_DECIM, 32'h3);
        wait_out(2);
        i0 = n_in_a;
        wait_out(5);
        cmp_reg("inputs per five outputs", 32'd20, 32'(n_in_a - i0));
        $display("filter test done");

        set_ai <= 23'h7fffa0;
        set_aq <= 23'h000060;
        set_bi <= 23'h000040;
        set_bq <= 23'h7fffc0;
        do_reset();
        setup(32'h1);
        wait_out(24);
        cmp_smp("corrected A-I", 24'h0, last_ai);
        cmp_smp("corrected A-Q", 24'h0, last_aq);
        cmp_smp("corrected B-I", 24'h0, last_bi);
        cmp_smp("corrected B-Q", 24'h0, last_bq);
        rd_chk("estimate A-I", `CFDC_OFF_ESTIMATE0, 32'hffffff, 32'hffff40);
        rd_chk("peak word A-I", `CFDC_OFF_PEAK_WORD, 32'h1f, 32'd15);
        set_ai <= 23'h3fffff;
        wait_out(4);
        cmp_smp("clamped A-I", 24'h7fffff, last_ai);
        rd_chk("held estimate", `CFDC_OFF_ESTIMATE0, 32'hffffff, 32'hffff40);
        set_ai <= 23'h7fffa0;
        wait_out(4);
        cmp_smp("old estimate A-I", 24'h0, last_ai);
        rd_chk("peak word after burst", `CFDC_OFF_PEAK_WORD, 32'h1f, 32'd15);
        $display("dc test done");
        give_verdict();
    end
endmodule

bind cfdc_top cfdc_top_properties #(.TAPS(TAPS)) i_cfdc_top_properties (
    .CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .IN_VALID_A(IN_VALID_A), .IN_VALID_B(IN_VALID_B), .OUT_AI(OUT_AI), .OUT_AQ(OUT_AQ),
    .OUT_BI(OUT_BI), .OUT_BQ(OUT_BQ));
